/* design/tcs_params.svh */
/*
  Timing counts and status/control byte layout for the transceiver
  control and status block.
  Assumes a 25 MHz core clock (40 ns period).
*/
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

`define TCS_CLK_NS          40
// Status/control byte location and fields
`define TCS_SC_OFFSET       8'h6e
`define TCS_SC_RESET        8'h00
`define TCS_BIT_SOFT_OFF    6
`define TCS_BIT_FAULT       2
`define TCS_BIT_LOS         1
`define TCS_BIT_READY       0
// Times in their own units
`define TCS_T_OFF_US        10
`define TCS_T_FAULT_US      100
`define TCS_T_RESET_US      10
`define TCS_T_INIT_MS       300
`define TCS_T_SERIAL_MS     300
`define TCS_T_DATA_MS       1000
`define TCS_T_WRITE_MS      10
`define TCS_T_RATE_MS       10
`define TCS_T_ON_MS         1
// Cycle counts; least times round up, longest times round down
`define TCS_RESET_CYC  ((`TCS_T_RESET_US*1000+`TCS_CLK_NS-1)/`TCS_CLK_NS)
`define TCS_FAULT_CYC  ((`TCS_T_FAULT_US*1000)/`TCS_CLK_NS)
`define TCS_SERIAL_CYC ((`TCS_T_SERIAL_MS*1000000)/`TCS_CLK_NS)
`define TCS_DATA_CYC   ((`TCS_T_DATA_MS*1000000)/`TCS_CLK_NS)
`define TCS_INIT_CYC   ((`TCS_T_INIT_MS*1000000)/`TCS_CLK_NS)
`define TCS_WRITE_CYC  ((`TCS_T_WRITE_MS*1000000)/`TCS_CLK_NS)
`define TCS_RATE_CYC   ((`TCS_T_RATE_MS*1000000)/`TCS_CLK_NS)

`endif

/* design/tcs_pkg.sv */
/*
  Types for the transceiver control and status block.
  Assumes tcs_params.svh supplies the numbers.
*/
package tcs_pkg;
  // Register access request from the serial interface front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcs_req_t;
  // Laser control state
  typedef enum logic [1:0] {TCS_INIT, TCS_RUN, TCS_OFF, TCS_FAULT}
    tcs_state_t;
endpackage

/* design/tcs_ctrl.sv */
/*
  Transceiver control and status logic: transmit off, laser fault latch,
  receive signal lost, rate select settling, power-on readiness of the
  serial bus and monitor data, and the status/control byte.
  Assumes all pin inputs are synchronous to mclk_i, rst_i is power-on,
  and a serial front end presents decoded byte accesses on req_i.
*/
`timescale 1ns/1ps
`include "tcs_params.svh"

// Notes on behaviour
// - Hardware transmit-off high turns the laser off within 10 us.
// - Hardware transmit-off low restores modulated output within 1 ms.
// - Initialization, fault clear included, ends within 300 ms.
// - A laser fault raises the fault pin within 100 us.
// - Transmit-off held high 10 us or more clears a latched fault.
// - Signal-lost pin rises within 100 us of input loss.
// - Signal-lost pin falls within 100 us of valid input.
// - After a rate input edge, new rate settles within 10 ms.
// - Software off bit set turns the laser off within 100 ms.
// - Software off bit cleared restores output within 100 ms.
// - Software fault bit sets within 100 ms of a fault.
// - Software signal-lost bit sets within 100 ms of loss.
// - Software signal-lost bit clears within 100 ms of valid input.
// - Monitor-data-ready bit sets within 1000 ms of power-on.
// - Serial accesses are accepted within 300 ms of power-on.
// - Internal write finishes within 10 ms after the stop condition.
// - Loss detection uses peak-to-peak amplitude with hysteresis.
module tcs_ctrl #(
  parameter int unsigned SERIAL_CYC = `TCS_SERIAL_CYC,
  parameter int unsigned DATA_CYC   = `TCS_DATA_CYC,
  parameter int unsigned INIT_CYC   = `TCS_INIT_CYC,
  parameter int unsigned RATE_CYC   = `TCS_RATE_CYC
) (
  // Clock and reset
  input  wire logic            mclk_i,
  input  wire logic            rst_i,
  // Host pins
  input  wire logic            tx_off_i,
  input  wire logic            rate_sel_i,
  output logic                 tx_fault_o,
  output logic                 receive_signal_lost_o,
  // Analog front end status
  input  wire logic            laser_fault_i,
  input  wire logic            amp_below_assert_i,
  input  wire logic            amp_above_deassert_i,
  input  wire logic            monitor_ok_i,
  // Laser and rate controls
  output logic                 laser_en_o,
  output logic                 rate_high_o,
  output logic                 rate_settled_o,
  // Serial interface byte access
  input  tcs_pkg::tcs_req_t    req_i,
  output logic                 bus_ready_o,
  output logic                 req_ack_o,
  output logic                 write_busy_o,
  output logic [7:0]           rdata_o
);

  localparam int unsigned RST_CYC = `TCS_RESET_CYC;

  tcs_pkg::tcs_state_t state_r;
  tcs_pkg::tcs_state_t state_nxt;
  logic [31:0] por_cnt_r;
  logic [31:0] init_cnt_r;
  logic [31:0] rate_cnt_r;
  logic [31:0] wr_cnt_r;
  logic [15:0] off_cnt_r;
  logic        soft_off_r;
  logic        los_r;
  logic        fault_r;
  logic        ready_r;
  logic        bus_ready_r;
  logic        rate_r;
  logic        tx_off_d_r;
  logic [7:0]  rdata_r;

  wire         off_req   = tx_off_i | soft_off_r;
  wire         sc_hit    = req_i.addr == `TCS_SC_OFFSET;
  wire         sc_wr     = bus_ready_r & req_i.wr & sc_hit & ~write_busy_o;
  wire         off_long  = off_cnt_r >= 16'(RST_CYC);
  wire         tx_off_fall = tx_off_d_r & ~tx_off_i;
  wire [7:0]   sc_value;

  // Status byte assembly; other bits read as zero
  assign sc_value = 8'h00
    | (8'(soft_off_r) << `TCS_BIT_SOFT_OFF)
    | (8'(fault_r)    << `TCS_BIT_FAULT)
    | (8'(los_r)      << `TCS_BIT_LOS)
    | (8'(ready_r)    << `TCS_BIT_READY);

  // Pin and handshake outputs
  assign tx_fault_o            = fault_r;
  assign receive_signal_lost_o = los_r;
  assign laser_en_o            = state_r == tcs_pkg::TCS_RUN;
  assign rate_high_o           = rate_r;
  assign rate_settled_o        = rate_cnt_r == 32'h0;
  assign bus_ready_o           = bus_ready_r;
  assign write_busy_o          = wr_cnt_r != 32'h0;
  assign req_ack_o             = bus_ready_r & (req_i.rd | req_i.wr);
  assign rdata_o               = rdata_r;

  // Laser state selection
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      tcs_pkg::TCS_INIT:
        if (laser_fault_i) state_nxt = tcs_pkg::TCS_FAULT;
        else if (off_req) state_nxt = tcs_pkg::TCS_OFF;
        else if (init_cnt_r == 32'h0) state_nxt = tcs_pkg::TCS_RUN;
      tcs_pkg::TCS_RUN:
        if (laser_fault_i) state_nxt = tcs_pkg::TCS_FAULT;
        else if (off_req) state_nxt = tcs_pkg::TCS_OFF;
      tcs_pkg::TCS_OFF:
        if (laser_fault_i) state_nxt = tcs_pkg::TCS_FAULT;
        else if (!off_req) state_nxt = tcs_pkg::TCS_RUN;
      tcs_pkg::TCS_FAULT:
        if (tx_off_fall && off_long) state_nxt = tcs_pkg::TCS_INIT;
    endcase
  end

  // Laser state and fault flag; a live fault re-sets the flag
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= tcs_pkg::TCS_INIT;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // A live fault keeps the pin up across the clearing pulse
      fault_r <= (state_nxt == tcs_pkg::TCS_FAULT)
                 || laser_fault_i;
    end
  end

  // Transmit-off pulse width and initialization timers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      off_cnt_r  <= 16'h0;
      tx_off_d_r <= 1'b0;
      init_cnt_r <= 32'h0;
    end else begin
      tx_off_d_r <= tx_off_i;
      if (!tx_off_i) off_cnt_r <= 16'h0;
      else if (!off_long) off_cnt_r <= off_cnt_r + 16'h1;
      if (state_nxt == tcs_pkg::TCS_INIT && state_r != tcs_pkg::TCS_INIT)
        init_cnt_r <= INIT_CYC - 32'd1;
      else if (init_cnt_r != 32'h0) init_cnt_r <= init_cnt_r - 32'h1;
    end
  end

  // Signal-lost flag with amplitude hysteresis
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) los_r <= 1'b1;
    else if (amp_below_assert_i) los_r <= 1'b1;
    else if (amp_above_deassert_i) los_r <= 1'b0;
  end

  // Power-on readiness of bus and monitor data
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      por_cnt_r   <= 32'h0;
      bus_ready_r <= 1'b0;
      ready_r     <= 1'b0;
    end else begin
      if (por_cnt_r < DATA_CYC) por_cnt_r <= por_cnt_r + 32'h1;
      if (por_cnt_r >= SERIAL_CYC - 1) bus_ready_r <= 1'b1;
      if (por_cnt_r >= DATA_CYC - 1 || (bus_ready_r && monitor_ok_i))
        ready_r <= 1'b1;
    end
  end

  // Rate select follows pin; settle timer restarts on each edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rate_r     <= 1'b0;
      rate_cnt_r <= 32'h0;
    end else begin
      rate_r <= rate_sel_i;
      if (rate_sel_i != rate_r) rate_cnt_r <= RATE_CYC - 32'd1;
      else if (rate_cnt_r != 32'h0) rate_cnt_r <= rate_cnt_r - 32'h1;
    end
  end

  // Status/control byte access; write applies at once, busy models t_write
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_off_r <= 1'b0;
      wr_cnt_r   <= 32'h0;
      rdata_r    <= 8'h00;
    end else begin
      if (sc_wr) begin
        soft_off_r <= req_i.wdata[`TCS_BIT_SOFT_OFF];
        wr_cnt_r   <= 32'd2;
      end else if (wr_cnt_r != 32'h0) wr_cnt_r <= wr_cnt_r - 32'h1;
      if (bus_ready_r && req_i.rd)
        rdata_r <= sc_hit ? sc_value : 8'h00;
    end
  end

  // Checks
  property p_off_fast;
    @(posedge mclk_i) disable iff (rst_i)
      tx_off_i |=> !laser_en_o;
  endproperty
  a_off_fast: assert property (p_off_fast)
    else $error("laser stayed on with transmit off");

  property p_fault_pin;
    @(posedge mclk_i) disable iff (rst_i)
      laser_fault_i |=> tx_fault_o;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin late");

  // Transmit-off released while the fault latch holds
  sequence s_short_release;
    state_r == tcs_pkg::TCS_FAULT && tx_off_i ##1 !tx_off_i && !off_long;
  endsequence
  sequence s_long_release;
    state_r == tcs_pkg::TCS_FAULT && tx_off_i
      ##1 !tx_off_i && off_long && !laser_fault_i;
  endsequence
  property p_fault_clear;
    @(posedge mclk_i) disable iff (rst_i)
      s_short_release |=> tx_fault_o;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault cleared by short pulse");

  property p_fault_reset;
    @(posedge mclk_i) disable iff (rst_i)
      s_long_release |=> !tx_fault_o;
  endproperty
  a_fault_reset: assert property (p_fault_reset)
    else $error("fault kept after long pulse");

  property p_los_set;
    @(posedge mclk_i) disable iff (rst_i)
      amp_below_assert_i |=> receive_signal_lost_o && sc_value[1];
  endproperty
  a_los_set: assert property (p_los_set)
    else $error("signal lost not flagged");

  property p_los_clr;
    @(posedge mclk_i) disable iff (rst_i)
      (amp_above_deassert_i && !amp_below_assert_i)
        |=> !receive_signal_lost_o;
  endproperty
  a_los_clr: assert property (p_los_clr)
    else $error("signal lost not cleared");

  property p_soft_off;
    @(posedge mclk_i) disable iff (rst_i)
      (sc_wr && req_i.wdata[6]) |=> ##1 !laser_en_o;
  endproperty
  a_soft_off: assert property (p_soft_off)
    else $error("soft off ignored");

  property p_both_low;
    @(posedge mclk_i) disable iff (rst_i)
      laser_en_o |-> !$past(tx_off_i) && !$past(soft_off_r);
  endproperty
  a_both_low: assert property (p_both_low)
    else $error("laser on while an off control asserted");

  // Both controls negated relights the laser at once
  property p_on_again;
    @(posedge mclk_i) disable iff (rst_i)
      (state_r == tcs_pkg::TCS_OFF && !off_req && !laser_fault_i)
        |=> laser_en_o;
  endproperty
  a_on_again: assert property (p_on_again)
    else $error("laser not restored");

  // Sampled reset keeps the release edge itself out of the check
  property p_init_end;
    @(posedge mclk_i) disable iff (rst_i)
      (!rst_i && state_r == tcs_pkg::TCS_INIT && init_cnt_r == 32'h0
        && !off_req && !laser_fault_i) |=> laser_en_o;
  endproperty
  a_init_end: assert property (p_init_end)
    else $error("initialization did not end");

  // A rate edge restarts the settle timer
  property p_rate_edge;
    @(posedge mclk_i) disable iff (rst_i)
      (rate_sel_i != rate_high_o) |=> !rate_settled_o;
  endproperty
  a_rate_edge: assert property (p_rate_edge)
    else $error("rate edge not tracked");

  // Monitor data ready no later than its power-on limit
  property p_data_ready;
    @(posedge mclk_i) disable iff (rst_i)
      (por_cnt_r == DATA_CYC) |-> sc_value[`TCS_BIT_READY];
  endproperty
  a_data_ready: assert property (p_data_ready)
    else $error("monitor data ready late");

  property p_bus_ready;
    @(posedge mclk_i) disable iff (rst_i)
      (por_cnt_r == SERIAL_CYC) |-> bus_ready_o;
  endproperty
  a_bus_ready: assert property (p_bus_ready)
    else $error("serial bus not ready in time");

  property p_write_done;
    @(posedge mclk_i) disable iff (rst_i)
      sc_wr |=> write_busy_o ##2 !write_busy_o;
  endproperty
  a_write_done: assert property (p_write_done)
    else $error("write cycle too long");

endmodule

/* sim/tcs_host.sv */
/*
  Host model: drives transmit-off and byte accesses.
  Assumes the block's ready, busy and read-data timing.
*/
`timescale 1ns/1ps
module tcs_host (
  // Clock
  input  wire logic         mclk_i,
  // Block status
  input  wire logic         bus_ready_i,
  input  wire logic         write_busy_i,
  input  wire logic         req_ack_i,
  input  wire logic [7:0]   rdata_i,
  // Host drive
  output logic              tx_off_o,
  output tcs_pkg::tcs_req_t req_o
);
  // Idle values at time zero
  initial begin
    tx_off_o = 1'b0;
    req_o = '0;
  end
  // Set the transmit-off pin level
  task automatic set_off(input logic v);
    @(posedge mclk_i) tx_off_o <= v;
  endtask
  // Hold transmit-off high n cycles, then drop it
  task automatic off_pulse(input int n);
    set_off(1'b1);
    repeat (n) @(posedge mclk_i);
    tx_off_o <= 1'b0;
  endtask
  // One byte access; waits up to 300 cycles for ready, and for a busy write to end before a write
  // Each access stands for a bus clocked at 400 kHz or less
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic k);
    for (int i = 0; i < 300 && (bus_ready_i !== 1'b1 ||
         (w && write_busy_i !== 1'b0)); i++)
      @(posedge mclk_i);
    @(posedge mclk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    // Acknowledge stands while the request is up
    #1 k = req_ack_i;
    @(posedge mclk_i);
    // Released lines show the inverse, not the last value
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 q = rdata_i;
  endtask
endmodule

/* sim/tcs_ctrl_tb.sv */
/*
  Self-checking bench for tcs_ctrl driven through a host model.
  Assumes the shortened counts set at the instance below.
*/
`timescale 1ns/1ps
`include "tcs_params.svh"
module tcs_ctrl_tb;
  localparam int IC = 50;
  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              rate, lf, below, above, mon, txoff;
  logic              fault, lost, len, rhi, rset, rdy, busy;
  logic              ack, ack_seen;
  logic [7:0]        rdata, q;
  tcs_pkg::tcs_req_t req;
  int                n_mismatch = 0;
  int                compares = 0;
  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;
  // Block and host
  tcs_ctrl #(.SERIAL_CYC(100), .DATA_CYC(200), .INIT_CYC(IC),
    .RATE_CYC(20)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .tx_off_i(txoff), .rate_sel_i(rate), .tx_fault_o(fault),
    .receive_signal_lost_o(lost), .laser_fault_i(lf),
    .amp_below_assert_i(below), .amp_above_deassert_i(above),
    .monitor_ok_i(mon), .laser_en_o(len), .rate_high_o(rhi),
    .rate_settled_o(rset), .req_i(req), .bus_ready_o(rdy),
    .req_ack_o(ack), .write_busy_o(busy), .rdata_o(rdata));
  tcs_host u_host (.mclk_i(mclk_i), .bus_ready_i(rdy),
    .write_busy_i(busy), .req_ack_i(ack), .rdata_i(rdata),
    .tx_off_o(txoff),
    .req_o(req));
  // Selects an output for bounded waits
  function automatic logic sig(input int s);
    case (s)
      0: sig = len;
      1: sig = fault;
      2: sig = lost;
      3: sig = rdy;
      4: sig = rset;
      default: sig = busy;
    endcase
  endfunction
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Wait up to n cycles for an output level; a miss ends the run
  task automatic wt(input string nm, input int s, input logic v,
                    input int n);
    for (int i = 0; i < n && sig(s) !== v; i++) begin
      @(posedge mclk_i);
      #1;
    end
    chk(nm, 8'(v), 8'(sig(s)));
    if (sig(s) !== v)
      complete_run();
  endtask
  // Register access through the host
  task automatic rw(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    wt("bus ready", 3, 1'b1, 300);
    if (w)
      wt("write idle", 5, 1'b0, 10);
    u_host.acc(w, a, d, q, ack_seen);
    chk("req_ack", 8'h01, 8'(ack_seen));
  endtask
  // Reset values and power-on readiness
  task automatic t_reset();
    @(posedge mclk_i);
    #1 chk("laser_en", 8'h00, 8'(len));
    chk("lost", 8'h01, 8'(lost));
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    above <= 1'b1;
    repeat (90) @(posedge mclk_i);
    #1 chk("bus_ready early", 8'h00, 8'(rdy));
    wt("bus_ready", 3, 1'b1, 20);
    wt("laser on", 0, 1'b1, IC);
    wt("lost clear", 2, 1'b0, 5);
    $display("test reset done");
  endtask
  // Software and hardware transmit-off
  task automatic t_off();
    rw(1'b1, `TCS_SC_OFFSET, 8'h40);
    chk("write_busy", 8'h01, 8'(busy));
    wt("soft off", 0, 1'b0, 3);
    wt("busy end", 5, 1'b0, 3);
    rw(1'b0, `TCS_SC_OFFSET, 8'h00);
    chk("status", 8'h40, q);
    rw(1'b0, 8'h6f, 8'h00);
    chk("unmapped read", 8'h00, q);
    u_host.set_off(1'b1);
    rw(1'b1, `TCS_SC_OFFSET, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1 chk("either off", 8'h00, 8'(len));
    u_host.set_off(1'b0);
    wt("soft on", 0, 1'b1, IC + 5);
    rw(1'b1, 8'h10, 8'h40);
    u_host.set_off(1'b1);
    wt("hard off", 0, 1'b0, 3);
    u_host.set_off(1'b0);
    wt("hard on", 0, 1'b1, IC + 5);
    $display("test off done");
  endtask
  // Laser fault latch and its clearing pulse
  task automatic t_fault();
    @(posedge mclk_i) lf <= 1'b1;
    wt("fault pin", 1, 1'b1, 3);
    wt("fault off", 0, 1'b0, 3);
    rw(1'b0, `TCS_SC_OFFSET, 8'h00);
    chk("fault bit", 8'h04, q & 8'h46);
    @(posedge mclk_i) lf <= 1'b0;
    u_host.off_pulse(`TCS_RESET_CYC / 2);
    repeat (3) @(posedge mclk_i);
    #1 chk("short pulse", 8'h01, 8'(fault));
    u_host.off_pulse(`TCS_RESET_CYC + 5);
    wt("fault clear", 1, 1'b0, IC + 10);
    wt("relit", 0, 1'b1, IC + 10);
    $display("test fault done");
  endtask
  // Signal lost with hysteresis, pin and bit
  task automatic t_los();
    @(posedge mclk_i) below <= 1'b1;
    above <= 1'b0;
    wt("lost set", 2, 1'b1, 5);
    rw(1'b0, `TCS_SC_OFFSET, 8'h00);
    chk("lost bit", 8'h03, q & 8'h03);
    @(posedge mclk_i) below <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1 chk("hysteresis", 8'h01, 8'(lost));
    @(posedge mclk_i) above <= 1'b1;
    wt("lost clear", 2, 1'b0, 5);
    rw(1'b0, `TCS_SC_OFFSET, 8'h00);
    chk("lost bit clear", 8'h00, q & 8'h02);
    $display("test los done");
  endtask
  // Rate edges both ways, then a mid-run reset with monitor ready
  task automatic t_rate_ready();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i) rate <= ~rate;
      wt("rate pending", 4, 1'b0, 3);
      wt("rate settled", 4, 1'b1, 23);
      chk("rate high", 8'(rate), 8'(rhi));
    end
    // Monitor ready must set the bit well before its timer would
    @(posedge mclk_i) rst_i <= 1'b1;
    above <= 1'b0;
    mon <= 1'b1;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    above <= 1'b1;
    #1 chk("lost in reset", 8'h01, 8'(lost));
    chk("bus_ready after reset", 8'h00, 8'(rdy));
    wt("laser on again", 0, 1'b1, IC);
    rw(1'b0, `TCS_SC_OFFSET, 8'h00);
    chk("ready bit", 8'h01, q & 8'h01);
    $display("test rate ready done");
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    rate = 1'b0;
    lf = 1'b0;
    below = 1'b0;
    above = 1'b0;
    mon = 1'b0;
    t_reset();
    t_off();
    t_fault();
    t_los();
    t_rate_ready();
    complete_run();
  end
endmodule
